//--- rtl/phy_mode_led_cfg.svh
// Offsets, field positions, reset values and codes of the PHY mode and indicator bank
`ifndef PHY_MODE_LED_CFG_SVH
`define PHY_MODE_LED_CFG_SVH

// Bank and register offsets on the bank-switched port
`define REG_BANK_MODE 3'h0
`define OFF_PACKET_MEMORY_INFO 4'h8
`define OFF_PHY_MODE_AND_INDICATOR_CONTROL 4'hA

// Memory information layout and values
`define MEM_SIZE_LSB 0
`define MEM_FREE_LSB 8
`define MEM_FIELD_W 8
`define MEM_UNIT_BYTES 2048
`define MEM_MULTIPLIER 1
`define MEM_SIZE_UNITS 8'h04
`define PACKET_MEMORY_INFO_RESET 16'h0404

// Control register layout and values
`define SPEED_SELECT_BIT 13
`define DUPLEX_SELECT_BIT 12
`define MAC_AUTO_NEGOTIATION_GATE_GATE_BIT 11
`define INDICATOR_A_LSB 5
`define INDICATOR_B_LSB 2
`define INDICATOR_SEL_W 3
`define CONTROL_WRITE_MASK 16'h38FC
`define CONTROL_RESET 16'h0000

// Indicator select codes
`define IND_LINK_ANY 3'h0
`define IND_RESERVED 3'h1
`define IND_LINK_10M 3'h2
`define IND_FULL_DUPLEX 3'h3
`define IND_ACTIVITY 3'h4
`define IND_LINK_100M 3'h5
`define IND_RECEIVE 3'h6
`define IND_TRANSMIT 3'h7

`endif

//--- rtl/phy_mode_led_pkg.sv
// Types shared by the PHY mode and indicator bank
package phy_mode_led_pkg;
   typedef logic [15:0] reg_word_t;
   typedef logic [2:0] indicator_sel_t;
   typedef logic [7:0] mem_units_t;
   typedef enum logic [1:0] {
      SRC_MAC_FORCED,
      SRC_PHY_FORCED,
      SRC_NEGOTIATED
   } mode_source_e;
endpackage

//--- rtl/indicator_mux.sv
// One indicator output selected from the PHY status signals
`timescale 1ns/1ps
`default_nettype none
`include "phy_mode_led_cfg.svh"

module indicator_mux
   import phy_mode_led_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire indicator_sel_t sel_i,
   input wire logic link_10m_indicator_i,
   input wire logic link_100m_indicator_i,
   input wire logic full_duplex_indicator_i,
   input wire logic activity_indicator_i,
   input wire logic receive_indicator_i,
   input wire logic transmit_indicator_i,
   output logic indicator_pin_o
);

   logic led_nxt;

   always_comb begin
      case (sel_i)
         `IND_LINK_ANY: led_nxt = link_100m_indicator_i | link_10m_indicator_i;
         `IND_LINK_10M: led_nxt = link_10m_indicator_i;
         `IND_FULL_DUPLEX: led_nxt = full_duplex_indicator_i;
         `IND_ACTIVITY: led_nxt = activity_indicator_i;
         `IND_LINK_100M: led_nxt = link_100m_indicator_i;
         `IND_RECEIVE: led_nxt = receive_indicator_i;
         `IND_TRANSMIT: led_nxt = transmit_indicator_i;
         default: led_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         indicator_pin_o <= 1'b0;
      end else begin
         indicator_pin_o <= led_nxt;
      end
   end

endmodule // indicator_mux

`default_nettype wire

//--- rtl/phy_mode_led_select_regs.sv
// Memory information and PHY mode / indicator select registers
`timescale 1ns/1ps
`default_nettype none
`include "phy_mode_led_cfg.svh"

module phy_mode_led_select_regs
   import phy_mode_led_pkg::*;
#(
   parameter mem_units_t MEM_SIZE = `MEM_SIZE_UNITS
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   // Bank-switched register port
   input wire logic [2:0] bank_i,
   input wire logic [3:0] addr_i,
   input wire logic [1:0] byte_en_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire reg_word_t wdata_i,
   output reg_word_t rdata_o,
   output logic rvalid_o,
   // Memory manager
   input wire logic mmu_reset_i,
   input wire logic free_update_i,
   input wire mem_units_t free_units_i,
   // PHY control register and negotiation outcome
   input wire logic phy_ctl_speed_i,
   input wire logic phy_ctl_duplex_i,
   input wire logic phy_negotiation_enable_i,
   input wire logic mac_auto_negotiation_gate_speed_100_i,
   input wire logic mac_auto_negotiation_gate_full_duplex_i,
   input wire logic mac_full_duplex_control_i,
   // PHY mode outputs
   output logic phy_speed_100_o,
   output logic phy_full_duplex_o,
   output logic phy_mac_auto_negotiation_gate_mode_o,
   output logic mac_full_duplex_o,
   // PHY status sources for the indicators
   input wire logic link_10m_indicator_i,
   input wire logic link_100m_indicator_i,
   input wire logic full_duplex_indicator_i,
   input wire logic activity_indicator_i,
   input wire logic receive_indicator_i,
   input wire logic transmit_indicator_i,
   output logic indicator_a_pin_o,
   output logic indicator_b_pin_o
);

   localparam int NUM_IND = 2;

   mem_units_t free_units_r;
   reg_word_t control_r;
   reg_word_t control_nxt;
   reg_word_t rdata_nxt;
   mode_source_e src;
   logic sel_mode_bank;
   logic hit_info;
   logic hit_ctrl;
   logic speed_nxt;
   logic duplex_nxt;
   logic speed_select_bit;
   logic duplex_select_bit;
   logic mac_auto_negotiation_gate;
   indicator_sel_t ind_sel [NUM_IND];
   logic [NUM_IND-1:0] ind_pin;

   // Address decode within the selected bank
   assign sel_mode_bank = (bank_i == `REG_BANK_MODE);
   assign hit_info = sel_mode_bank && (addr_i == `OFF_PACKET_MEMORY_INFO);
   assign hit_ctrl = sel_mode_bank && (addr_i == `OFF_PHY_MODE_AND_INDICATOR_CONTROL);

   // Field views of the control register
   assign speed_select_bit = control_r[`SPEED_SELECT_BIT];
   assign duplex_select_bit = control_r[`DUPLEX_SELECT_BIT];
   assign mac_auto_negotiation_gate = control_r[`MAC_AUTO_NEGOTIATION_GATE_GATE_BIT];
   assign ind_sel[0] = control_r[`INDICATOR_A_LSB +: `INDICATOR_SEL_W];
   assign ind_sel[1] = control_r[`INDICATOR_B_LSB +: `INDICATOR_SEL_W];

   // Free memory tracks the manager; its reset command wins over an update
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         free_units_r <= MEM_SIZE;
      end else if (mmu_reset_i) begin
         free_units_r <= MEM_SIZE;
      end else if (free_update_i) begin
         free_units_r <= free_units_i;
      end
   end

   // Byte-lane write; reserved bits never store so they read back zero
   always_comb begin
      control_nxt = control_r;
      if (byte_en_i[0]) begin
         control_nxt[7:0] = wdata_i[7:0];
      end
      if (byte_en_i[1]) begin
         control_nxt[15:8] = wdata_i[15:8];
      end
      control_nxt = control_nxt & `CONTROL_WRITE_MASK;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         control_r <= `CONTROL_RESET;
      end else if (wr_i && hit_ctrl) begin
         control_r <= control_nxt;
      end
   end

   // Read mux; unmapped offsets answer zero
   always_comb begin
      rdata_nxt = '0;
      if (hit_info) begin
         rdata_nxt[`MEM_FREE_LSB +: `MEM_FIELD_W] = free_units_r;
         rdata_nxt[`MEM_SIZE_LSB +: `MEM_FIELD_W] = MEM_SIZE;
      end else if (hit_ctrl) begin
         rdata_nxt = control_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= rd_i;
      end
   end

   // Which party decides speed and duplex
   always_comb begin
      if (!mac_auto_negotiation_gate) begin
         src = SRC_MAC_FORCED;
      end else if (!phy_negotiation_enable_i) begin
         src = SRC_PHY_FORCED;
      end else begin
         src = SRC_NEGOTIATED;
      end
   end

   always_comb begin
      case (src)
         SRC_MAC_FORCED: begin
            speed_nxt = speed_select_bit;
            duplex_nxt = duplex_select_bit;
         end
         SRC_PHY_FORCED: begin
            speed_nxt = phy_ctl_speed_i;
            duplex_nxt = phy_ctl_duplex_i;
         end
         SRC_NEGOTIATED: begin
            speed_nxt = mac_auto_negotiation_gate_speed_100_i;
            duplex_nxt = mac_auto_negotiation_gate_full_duplex_i;
         end
         default: begin
            speed_nxt = 1'b0;
            duplex_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         phy_speed_100_o <= 1'b0;
         phy_full_duplex_o <= 1'b0;
      end else begin
         phy_speed_100_o <= speed_nxt;
         phy_full_duplex_o <= duplex_nxt;
      end
   end

   // Manual unless both enables are set
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         phy_mac_auto_negotiation_gate_mode_o <= 1'b0;
      end else begin
         phy_mac_auto_negotiation_gate_mode_o <= (src == SRC_NEGOTIATED);
      end
   end

   // MAC duplex is the host's setting, not the PHY's; a mismatch is a host fault
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mac_full_duplex_o <= 1'b0;
      end else begin
         mac_full_duplex_o <= mac_full_duplex_control_i;
      end
   end

   // Two independent indicator selectors
   for (genvar i = 0; i < NUM_IND; i++) begin : g_ind
      indicator_mux u_mux (
         .clk_i(clk_i),
         .nrst_i(nrst_i),
         .sel_i(ind_sel[i]),
         .link_10m_indicator_i(link_10m_indicator_i),
         .link_100m_indicator_i(link_100m_indicator_i),
         .full_duplex_indicator_i(full_duplex_indicator_i),
         .activity_indicator_i(activity_indicator_i),
         .receive_indicator_i(receive_indicator_i),
         .transmit_indicator_i(transmit_indicator_i),
         .indicator_pin_o(ind_pin[i])
      );
   end

   // Mux outputs are already flops; renamed only
   assign indicator_a_pin_o = ind_pin[0];
   assign indicator_b_pin_o = ind_pin[1];

endmodule // phy_mode_led_select_regs

`default_nettype wire

//--- testbench/regs_asserts.sv
// Port checker for the PHY mode and indicator register bank
`timescale 1ns/1ps
`default_nettype none
module regs_chk
   import phy_mode_led_pkg::*;
#(
   parameter mem_units_t MEM_SIZE = 8'h04
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [2:0] bank_i,
   input wire logic [3:0] addr_i,
   input wire logic rd_i,
   input wire reg_word_t rdata_o,
   input wire logic rvalid_o,
   input wire logic mmu_reset_i,
   input wire logic free_update_i,
   input wire mem_units_t free_units_i,
   input wire logic mac_auto_negotiation_gate_speed_100_i,
   input wire logic mac_auto_negotiation_gate_full_duplex_i,
   input wire logic mac_full_duplex_control_i,
   input wire logic phy_speed_100_o,
   input wire logic phy_full_duplex_o,
   input wire logic phy_mac_auto_negotiation_gate_mode_o,
   input wire logic mac_full_duplex_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   wire logic rd8 = rd_i && bank_i == 3'h0 && addr_i == 4'h8;
   wire logic hit = bank_i == 3'h0 && (addr_i == 4'h8 || addr_i == 4'hA);
   read_answer_a: assert property (rd_i |=> rvalid_o) else $error("read not answered");
   no_spurious_a: assert property (!rd_i |=> !rvalid_o) else $error("stray rvalid");
   size_low_a: assert property (rd8 |=> rdata_o[7:0] == MEM_SIZE)
      else $error("size byte wrong");
   free_reset_a: assert property (mmu_reset_i ##1 (rd8 && !free_update_i)
      |=> rdata_o[15:8] == MEM_SIZE) else $error("free not reloaded");
   free_load_a: assert property ((free_update_i && !mmu_reset_i)
      ##1 (rd8 && !free_update_i && !mmu_reset_i)
      |=> rdata_o[15:8] == $past(free_units_i, 2)) else $error("free value wrong");
   unmapped_zero_a: assert property (rd_i && !hit |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   neg_speed_a: assert property (phy_mac_auto_negotiation_gate_mode_o |-> phy_speed_100_o == $past(mac_auto_negotiation_gate_speed_100_i))
      else $error("negotiated speed wrong");
   neg_duplex_a: assert property (phy_mac_auto_negotiation_gate_mode_o
      |-> phy_full_duplex_o == $past(mac_auto_negotiation_gate_full_duplex_i)) else $error("negotiated duplex wrong");
   mac_duplex_a: assert property ($past(nrst_i)
      |-> mac_full_duplex_o == $past(mac_full_duplex_control_i)) else $error("mac duplex wrong");
   cover property (phy_mac_auto_negotiation_gate_mode_o ##1 !phy_mac_auto_negotiation_gate_mode_o);
   cover property (rd8 ##1 rvalid_o);
   cover property (mmu_reset_i ##1 rd8);
endmodule // regs_chk
bind phy_mode_led_select_regs regs_chk #(.MEM_SIZE(MEM_SIZE)) u_regs_chk (.*);
`default_nettype wire

//--- testbench/phy_side_model.sv
// Internal PHY side: status levels, control bits and negotiation outcome
`timescale 1ns/1ps
`default_nettype none
module phy_side_model (
   input wire logic clk_i,
   input wire logic step_i,
   output logic [5:0] status_o,
   output logic [4:0] mode_o
);
   // Levels move only on request, so the bench can predict them
   initial begin
      status_o = 6'h00;
      mode_o = 5'h00;
   end
   always @(posedge clk_i) begin
      if (step_i) begin
         status_o <= 6'($urandom);
         mode_o <= 5'($urandom);
      end
   end
endmodule // phy_side_model
`default_nettype wire

//--- testbench/phy_mode_led_select_regs_tb.sv
// Self-checking bench for the PHY mode and indicator register bank
`timescale 1ns/1ps
`default_nettype none
module phy_mode_led_select_regs_tb
   import phy_mode_led_pkg::*;
;
   logic clk_i = 1'b0, nrst_i = 1'b0, step = 1'b0, mac_full_duplex_control_i = 1'b0;
   logic wr_i = 1'b0, rd_i = 1'b0, mmu_reset_i = 1'b0, free_update_i = 1'b0;
   logic [2:0] bank_i = 3'h0;
   logic [3:0] addr_i = 4'h0;
   logic [1:0] byte_en_i = 2'h3;
   reg_word_t wdata_i = 16'h0000;
   mem_units_t free_units_i = 8'h00;
   reg_word_t rdata_o, ctl;
   logic rvalid_o, phy_speed_100_o, phy_full_duplex_o, phy_mac_auto_negotiation_gate_mode_o, mac_full_duplex_o;
   logic indicator_a_pin_o, indicator_b_pin_o;
   logic [5:0] st;
   logic [4:0] md;
   logic [2:0] e;
   reg_word_t exp_q[$];
   int num_errors = 0, num_checks = 0;
   wire logic link_10m_indicator_i = st[0], full_duplex_indicator_i = st[1];
   wire logic activity_indicator_i = st[2], link_100m_indicator_i = st[3];
   wire logic receive_indicator_i = st[4], transmit_indicator_i = st[5];
   wire logic phy_ctl_speed_i = md[0], phy_ctl_duplex_i = md[1];
   wire logic phy_negotiation_enable_i = md[2], mac_auto_negotiation_gate_speed_100_i = md[3];
   wire logic mac_auto_negotiation_gate_full_duplex_i = md[4];
   phy_mode_led_select_regs u_phy_mode_led_select_regs (.*);
   phy_side_model u_phy_side_model (.clk_i(clk_i), .step_i(step), .status_o(st), .mode_o(md));
   always #20 clk_i = ~clk_i;
   task automatic chk(input reg_word_t got, input reg_word_t exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobes {wr, rd, mmu reset, free update, partner step} for one edge
   task automatic go(input logic [4:0] s);
      {wr_i, rd_i, mmu_reset_i, free_update_i, step} = s;
      @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input reg_word_t d, input logic [1:0] be, input logic s);
      {bank_i, addr_i, wdata_i, byte_en_i} = {3'h0, a, d, be};
      go({4'h8, s});
   endtask
   task automatic rd(input logic [2:0] b, input logic [3:0] a, input reg_word_t x);
      exp_q.push_back(x);
      {bank_i, addr_i} = {b, a};
      go(5'h08);
   endtask
   // Mode and indicator levels settle after one quiet edge; three are given
   task automatic settle;
      repeat (3) go(5'h00);
   endtask
   function automatic logic led(input logic [2:0] c, input logic [5:0] s);
      case (c)
         3'h0: return s[0] | s[3];
         3'h1: return 1'b0;
         default: return s[c - 3'h2];
      endcase
   endfunction
   always @(negedge clk_i) begin
      if (rvalid_o === 1'b1 && exp_q.size() > 0) chk(rdata_o, exp_q.pop_front());
   end
   task automatic final_report;
      if (exp_q.size() != 0) num_errors++;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #800000;
      num_errors++;
      final_report();
   end
   initial begin
      void'($urandom(32'h8CCF));
      repeat (20) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      rd(3'h0, 4'h8, 16'h0404);
      rd(3'h0, 4'hA, 16'h0000);
      rd(3'h0, 4'h0, 16'h0000);
      rd(3'h1, 4'h8, 16'h0000);
      go(5'h01);
      settle();
      chk({14'h0, indicator_a_pin_o, indicator_b_pin_o}, {14'h0, {2{st[0] | st[3]}}});
      $display("test reset done");
      wr(4'hA, 16'hFFFF, 2'h3, 1'b0);
      rd(3'h0, 4'hA, 16'h38FC);
      wr(4'h8, 16'h0000, 2'h3, 1'b0);
      rd(3'h0, 4'h8, 16'h0404);
      free_units_i = 8'($urandom);
      go(5'h02);
      rd(3'h0, 4'h8, {free_units_i, 8'h04});
      go(5'h06);
      rd(3'h0, 4'h8, 16'h0404);
      go(5'h00);
      $display("test memory done");
      for (int i = 0; i < 40; i++) begin
         ctl = 16'($urandom) & 16'h38FC;
         wr(4'hA, ctl, 2'h3, 1'b1);
         settle();
         if (!ctl[11]) e = {1'b0, ctl[13], ctl[12]};
         else if (md[2]) e = {1'b1, md[3], md[4]};
         else e = {1'b0, md[0], md[1]};
         chk({13'h0, phy_mac_auto_negotiation_gate_mode_o, phy_speed_100_o, phy_full_duplex_o}, {13'h0, e});
         mac_full_duplex_control_i = e[0];
         settle();
         chk({15'h0, mac_full_duplex_o}, {15'h0, e[0]});
      end
      $display("test mode done");
      for (int i = 0; i < 32; i++) begin
         wr(4'hA, {8'h00, 3'(i / 4), 3'(7 - i / 4), 2'h0}, 2'h1, 1'b1);
         settle();
         e = 3'(i / 4);
         chk({14'h0, indicator_a_pin_o, indicator_b_pin_o},
            {14'h0, led(e, st), led(3'h7 - e, st)});
      end
      rd(3'h0, 4'hA, {ctl[15:8], 8'hE0});
      // High lane only: low byte must keep the last indicator codes
      wr(4'hA, 16'h28FF, 2'h2, 1'b0);
      rd(3'h0, 4'hA, 16'h28E0);
      go(5'h00);
      $display("test indicator done");
      free_units_i = 8'h01;
      go(5'h02);
      rd(3'h0, 4'h8, 16'h0104);
      nrst_i = 1'b0;
      settle();
      nrst_i = 1'b1;
      rd(3'h0, 4'h8, 16'h0404);
      rd(3'h0, 4'hA, 16'h0000);
      go(5'h00);
      $display("test mid reset done");
      final_report();
   end
endmodule // phy_mode_led_select_regs_tb
`default_nettype wire
